// file: core/pirg_glue.sv
// Pin glue: reset pin, interrupt pin, port C keyboard interrupt,
// port direction registers and port D analog-shared reads.
// Assumes classic Wishbone slave access and pins synchronous to clk
// except the interrupt pin, reset pin, oscillator input and port C, which are synchronised here.
//
// Overview of operation
// R1: A low on the reset pin is a reset request for the whole controller.
// R2: Any internal reset source drives the reset pin low.
// R3: The interrupt pin senses falling edges, or edges and low level.
// R4: When enabled, all eight port C pins are ORed into the interrupt.
// R5: Port C interrupts are always falling-edge only.
// R6: Ports A, B and C default to input direction at any reset.
// R7: The converter is off after reset; port D then reads as plain inputs.
// R8: While enabled, the channel select picks exactly one port D pin; codes 5 to 7 pick none.
// R9: While enabled, the selected port D pin reads as 0.
// R10: While enabled, unselected port D pins read their true level.
// R11: The operating clock runs at half the oscillator frequency.
// R12: Interrupt pin and port C are synchronised before edge detection.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
module pirg_glue #(
  parameter bit LEVEL_SENSE = 1'b1   // Option bit: 1 edge and level
) (
  input  wire logic        clk,            // System clock, 10 MHz
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic        osc_in,         // Oscillator clock input
  output logic             op_clk,         // Operating clock, osc / 2
  input  wire logic        reset_pin_i,    // Reset pin level
  output logic             reset_pin_o,    // Reset pin drive value
  output logic             reset_pin_oe_n, // Reset pin enable, low drives
  input  wire logic        wdog_rst,       // Watchdog timeout reset
  input  wire logic        por_rst,        // Power-on reset
  input  wire logic        illegal_rst,    // Illegal address reset
  input  wire logic        stop_rst,       // Disabled stop reset
  input  wire logic        lvr_rst,        // Low-voltage reset
  output logic             sys_reset_req,  // Reset request to core
  input  wire logic        irq_pin,        // Interrupt pin, active low
  output logic             cpu_irq_req,    // Interrupt request to CPU
  input  wire logic [6:0]  first_port_lines,    // Port A pins
  output logic      [6:0]  first_port_dir,      // Port A direction, 1 out
  input  wire logic [7:0]  portb_lines,         // Port B pins
  output logic      [7:0]  portb_dir,           // Port B direction
  input  wire logic [7:0]  keyboard_port_lines, // Port C pins
  output logic      [7:0]  keyboard_port_dir,   // Port C direction
  input  wire logic [4:0]  analog_shared_inputs, // Port D pins
  output logic             adc_enable,     // Converter enable
  output logic      [4:0]  adc_channel_sel,// One-hot analog select
  output logic             irq_out,        // Level interrupt
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data
  output logic      [31:0] wb_dat_o,       // Wishbone read data
  output logic             wb_ack_o        // Wishbone acknowledge
);
  logic [6:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_c;
  logic        adc_en;
  logic [2:0]  adc_ch;
  logic        irq_en;
  logic [2:0]  ev_stat;
  logic [2:0]  ev_mask;
  logic [4:0]  rst_cause;
  logic        pin_level;
  logic        pin_fall;
  logic [7:0]  pc_level;
  logic [7:0]  pc_fall;
  logic        rst_pin_s1;
  logic        rst_pin_s2;
  logic [7:0]  rst_cnt;
  logic        osc_s1;
  logic        osc_s2;
  logic        osc_prev;
  logic        access;
  logic        wr;
  logic [4:0]  int_src;
  logic [4:0]  pd_read;
  logic [2:0]  ev_set;
  logic        irq_raw;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = access & wb_we_i & wb_sel_i[0];

  // ==========================================================
  // Operating clock divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1   <= 1'b0;
      osc_s2   <= 1'b0;
      osc_prev <= 1'b0;
      op_clk   <= 1'b0;
    end else begin
      osc_s1   <= osc_in;
      osc_s2   <= osc_s1;
      osc_prev <= osc_s2;
      // R11: toggle on each oscillator rise
      if (osc_s2 & ~osc_prev)
        op_clk <= ~op_clk;
    end
  end

  // ==========================================================
  // Reset pin
  assign int_src = {wdog_rst, por_rst, illegal_rst, stop_rst, lvr_rst};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_s1 <= 1'b1;
      rst_pin_s2 <= 1'b1;
      rst_cnt    <= 8'h00;
      rst_cause  <= 5'h00;
    end else begin
      rst_pin_s1 <= reset_pin_i;
      rst_pin_s2 <= rst_pin_s1;
      // R2: hold the pin low for a minimum pulse
      if (|int_src)
        rst_cnt <= 8'(pirg_pkg::RST_PULSE_CYC);
      else if (rst_cnt != 8'h00)
        rst_cnt <= rst_cnt - 8'h01;
      if (wr && wb_adr_i == pirg_pkg::ADDR_RST_CAUSE)
        rst_cause <= (rst_cause & ~wb_dat_i[4:0]) | int_src;
      else
        rst_cause <= rst_cause | int_src;
    end
  end

  // R2: pulldown while any source is active
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_n = ~((|int_src) | (rst_cnt != 8'h00));
  // R1: low pin level requests reset
  assign sys_reset_req  = ~rst_pin_s2 | (|int_src);

  a_rst_drive: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(por_rst) |-> !reset_pin_oe_n) // R2
    else $error("reset pin not driven on internal reset");

  a_rst_request: assert property (@(posedge clk) disable iff (!rst_n)
    (!rst_pin_s2) |-> sys_reset_req) // R1
    else $error("low reset pin gave no reset request");

  // ==========================================================
  // Interrupt pin and port C sensing
  pirg_fall_det u_pin_det (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (irq_pin),
    .level (pin_level),
    .fall  (pin_fall)
  );

  // R5: port C edges only
  genvar gi;
  generate
    for (gi = 0; gi < pirg_pkg::PC_W; gi++) begin : g_pc
      pirg_fall_det u_pc_det (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (keyboard_port_lines[gi]),
        .level (pc_level[gi]),
        .fall  (pc_fall[gi])
      );
    end
  endgenerate

  always_comb begin
    ev_set = 3'h0;
    // R3: edge, or edge plus low level
    ev_set[pirg_pkg::EV_PIN_BIT] = irq_en &
      (pin_fall | (LEVEL_SENSE & ~pin_level));
    // R4: OR of port C edges
    ev_set[pirg_pkg::EV_PORTC_BIT] = irq_en & (|pc_fall);
    ev_set[pirg_pkg::EV_RST_BIT] = |int_src;
  end

  // ==========================================================
  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ev_stat <= 3'h0;
    else if (wr && wb_adr_i == pirg_pkg::ADDR_IRQ_STAT)
      ev_stat <= (ev_stat & ~wb_dat_i[2:0]) | ev_set;
    else
      ev_stat <= ev_stat | ev_set;
  end

  assign irq_raw     = |(ev_stat & ev_mask);
  assign irq_out     = irq_raw;
  assign cpu_irq_req = |(ev_stat[1:0] & ev_mask[1:0]);

  a_pc_edge_only: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_en && (&pc_level) && $stable(pc_level) && !pin_fall &&
     pin_level && !ev_stat[pirg_pkg::EV_PORTC_BIT]) |=>
      !ev_stat[pirg_pkg::EV_PORTC_BIT]) // R5
    else $error("port C level set its flag");

  a_pc_or: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_en && |pc_fall) |=> ev_stat[pirg_pkg::EV_PORTC_BIT]) // R4
    else $error("port C edge lost");

  a_pin_sense: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_en && (pin_fall || (LEVEL_SENSE && !pin_level))) |=>
      ev_stat[pirg_pkg::EV_PIN_BIT]) // R3
    else $error("interrupt pin event lost");

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_a  <= pirg_pkg::DIR_RESET[6:0];
      dir_b  <= pirg_pkg::DIR_RESET;
      dir_c  <= pirg_pkg::DIR_RESET;
      adc_en <= 1'b0;
      adc_ch <= 3'h0;
      irq_en <= 1'b0;
      ev_mask <= 3'h0;
    end else if (wr) begin
      unique case (wb_adr_i)
        // R6: direction registers
        pirg_pkg::ADDR_PORTA_DIR: dir_a <= wb_dat_i[6:0];
        pirg_pkg::ADDR_PORTB_DIR: dir_b <= wb_dat_i[7:0];
        pirg_pkg::ADDR_PORTC_DIR: dir_c <= wb_dat_i[7:0];
        pirg_pkg::ADDR_ADC_CTRL: begin
          adc_en <= wb_dat_i[pirg_pkg::ADC_EN_BIT];
          adc_ch <= wb_dat_i[2:0];
        end
        pirg_pkg::ADDR_IRQ_CTRL: irq_en <= wb_dat_i[pirg_pkg::IRQ_EN_BIT];
        pirg_pkg::ADDR_IRQ_MASK: ev_mask <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  assign first_port_dir    = dir_a;
  assign portb_dir         = dir_b;
  assign keyboard_port_dir = dir_c;
  // R7: converter off after reset
  assign adc_enable        = adc_en;

  // R8: exactly one channel; codes above four fold to none
  always_comb begin
    adc_channel_sel = 5'h00;
    if (adc_en && adc_ch < 3'(pirg_pkg::PD_W))
      adc_channel_sel[adc_ch] = 1'b1;
  end

  // R9: selected pin reads 0; R10: others true
  assign pd_read = analog_shared_inputs & ~adc_channel_sel;

  a_pd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (adc_en && adc_ch < 3'(pirg_pkg::PD_W)) |->
      pd_read[adc_ch] == 1'b0) // R9
    else $error("selected analog pin read as one");

  a_pd_true: assert property (@(posedge clk) disable iff (!rst_n)
    !adc_en |-> pd_read == analog_shared_inputs) // R7
    else $error("port D read altered while converter off");

  a_dir_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> (dir_a == 7'h00 && dir_c == 8'h00)) // R6
    else $error("port direction not input after reset");

  // ==========================================================
  // Wishbone read and ack, one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        unique case (wb_adr_i)
          pirg_pkg::ADDR_PORTA_DATA: wb_dat_o <= {25'h0, first_port_lines};
          pirg_pkg::ADDR_PORTB_DATA: wb_dat_o <= {24'h0, portb_lines};
          pirg_pkg::ADDR_PORTC_DATA: wb_dat_o <= {24'h0, keyboard_port_lines};
          pirg_pkg::ADDR_PORTD_DATA: wb_dat_o <= {27'h0, pd_read};
          pirg_pkg::ADDR_PORTA_DIR:  wb_dat_o <= {25'h0, dir_a};
          pirg_pkg::ADDR_PORTB_DIR:  wb_dat_o <= {24'h0, dir_b};
          pirg_pkg::ADDR_PORTC_DIR:  wb_dat_o <= {24'h0, dir_c};
          pirg_pkg::ADDR_ADC_CTRL:   wb_dat_o <= {28'h0, adc_en, adc_ch};
          pirg_pkg::ADDR_IRQ_CTRL:   wb_dat_o <= {31'h0, irq_en};
          pirg_pkg::ADDR_IRQ_STAT:   wb_dat_o <= {29'h0, ev_stat};
          pirg_pkg::ADDR_IRQ_MASK:   wb_dat_o <= {29'h0, ev_mask};
          pirg_pkg::ADDR_RST_CAUSE:  wb_dat_o <= {27'h0, rst_cause};
          default:                   wb_dat_o <= pirg_pkg::RD_UNMAPPED;
        endcase
      end
    end
  end
endmodule : pirg_glue

// file: pkg/pirg_pkg.sv
// Package for the pin, interrupt and reset glue block.
// Assumes a 10 MHz system clock and a classic Wishbone register master.
package pirg_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_PORTA_DATA = 8'h00;
  localparam logic [7:0] ADDR_PORTB_DATA = 8'h04;
  localparam logic [7:0] ADDR_PORTC_DATA = 8'h08;
  localparam logic [7:0] ADDR_PORTD_DATA = 8'h0C;
  localparam logic [7:0] ADDR_PORTA_DIR  = 8'h10;
  localparam logic [7:0] ADDR_PORTB_DIR  = 8'h14;
  localparam logic [7:0] ADDR_PORTC_DIR  = 8'h18;
  localparam logic [7:0] ADDR_ADC_CTRL   = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h28;
  localparam logic [7:0] ADDR_RST_CAUSE  = 8'h2C;
  // ==========================================================
  // Field layout
  localparam int PA_W          = 7;
  localparam int PB_W          = 8;
  localparam int PC_W          = 8;
  localparam int PD_W          = 5;
  localparam int CHSEL_W       = 3;
  localparam int ADC_EN_BIT    = 3;
  localparam int IRQ_EN_BIT    = 0;
  localparam int EV_W          = 3;
  localparam int EV_PIN_BIT    = 0;
  localparam int EV_PORTC_BIT  = 1;
  localparam int EV_RST_BIT    = 2;
  localparam int RSRC_W        = 5;
  localparam logic [7:0]  DIR_RESET  = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int RST_PULSE_NS    = 1000;
  localparam int RST_PULSE_CYC   =
    (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SYNC_STAGES     = 2;
endpackage : pirg_pkg

// file: core/pirg_fall_det.sv
// Two-flop synchroniser with falling-edge detector for one pin.
// Assumes the pin is asynchronous and idles high.
`timescale 1ns/10ps
module pirg_fall_det (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic pin,      // Raw pin level
  output logic      level,    // Synchronised level
  output logic      fall      // One-cycle pulse on high to low
);
  logic meta;
  logic prev;

  // ==========================================================
  // Synchroniser: meta is read only by level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  // R12: one pulse per edge
  assign fall = prev & ~level;

  // R12: exactly one request per edge
  a_fall_single: assert property (@(posedge clk) disable iff (!rst_n)
    fall |=> !fall) else $error("falling edge pulse longer than one cycle");
endmodule : pirg_fall_det

// file: verif/pirg_pins_model.sv
// Far-side model: reset switch, interrupt switch, keyboard, clock.
// Assumes pull-ups on all pins, so a released line reads high.
`timescale 1ns/10ps
module pirg_pins_model (
  input  wire logic       ext_rst,  // Press reset switch
  input  wire logic       irq_low,  // Press interrupt switch
  input  wire logic [7:0] key_low,  // Pressed keys
  input  wire logic       rst_o,    // Device reset drive value
  input  wire logic       rst_oe_n, // Device drive enable, low
  output logic            osc_in,   // Free-running external clock
  output logic            rst_pin,  // Resolved reset line
  output logic            irq_pin,  // Interrupt line
  output logic      [7:0] keys      // Keyboard lines
);
  // ==========================================================
  // External clock, 2.5 MHz
  initial osc_in = 1'b0;
  always #200 osc_in = ~osc_in;
  // ==========================================================
  // wired reset line
  assign rst_pin = (ext_rst || (!rst_oe_n && !rst_o)) ? 1'b0 : 1'b1;
  assign irq_pin = irq_low ? 1'b0 : 1'b1;
  assign keys    = ~key_low;
endmodule : pirg_pins_model

// file: verif/pirg_glue_tb_top.sv
// Self-checking bench for the pin glue block.
// Assumes pirg_pins_model on the pins and a Wishbone master here.
`timescale 1ns/10ps
module pirg_glue_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        osc_in, op_clk, rst_pin, rst_o, rst_oe_n, sys_req;
  logic        irq_pin, cpu_irq, cpu_irq_e, adc_en, irq_out, ack, op_q;
  logic        req = 1'b0, we = 1'b0, ext_rst = 1'b0, irq_low = 1'b0;
  logic [4:0]  src = 5'h00, pd = 5'h1F, adc_sel;
  logic [6:0]  pa = 7'h55, pa_dir;
  logic [7:0]  pb = 8'hA6, pb_dir, pc, pc_dir, key_low = 8'h00;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dwr = 32'h0, drd;
  int          failures = 0, n_compared = 0, cyc_cnt = 0, tgl = 0, t0;

  always #50 clk = ~clk;

  pirg_pins_model u_pins (.ext_rst(ext_rst), .irq_low(irq_low),
    .key_low(key_low), .rst_o(rst_o), .rst_oe_n(rst_oe_n),
    .osc_in(osc_in), .rst_pin(rst_pin), .irq_pin(irq_pin), .keys(pc));

  pirg_glue #(.LEVEL_SENSE(1'b1)) u_dut (.clk(clk), .rst_n(rst_n),
    .osc_in(osc_in), .op_clk(op_clk), .reset_pin_i(rst_pin),
    .reset_pin_o(rst_o), .reset_pin_oe_n(rst_oe_n), .wdog_rst(src[4]),
    .por_rst(src[3]), .illegal_rst(src[2]), .stop_rst(src[1]),
    .lvr_rst(src[0]), .sys_reset_req(sys_req), .irq_pin(irq_pin),
    .cpu_irq_req(cpu_irq), .first_port_lines(pa),
    .first_port_dir(pa_dir), .portb_lines(pb), .portb_dir(pb_dir),
    .keyboard_port_lines(pc), .keyboard_port_dir(pc_dir),
    .analog_shared_inputs(pd), .adc_enable(adc_en),
    .adc_channel_sel(adc_sel), .irq_out(irq_out), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack));

  // Edge-only option instance, watched through its interrupt request
  pirg_glue #(.LEVEL_SENSE(1'b0)) u_dut_edge (.clk(clk), .rst_n(rst_n),
    .osc_in(osc_in), .op_clk(), .reset_pin_i(rst_pin), .reset_pin_o(),
    .reset_pin_oe_n(), .wdog_rst(src[4]), .por_rst(src[3]),
    .illegal_rst(src[2]), .stop_rst(src[1]), .lvr_rst(src[0]),
    .sys_reset_req(), .irq_pin(irq_pin), .cpu_irq_req(cpu_irq_e),
    .first_port_lines(pa), .first_port_dir(), .portb_lines(pb),
    .portb_dir(), .keyboard_port_lines(pc), .keyboard_port_dir(),
    .analog_shared_inputs(pd), .adc_enable(), .adc_channel_sel(),
    .irq_out(), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dwr), .wb_dat_o(),
    .wb_ack_o());

  // ==========================================================
  // Bus, compare and closing tasks
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dwr <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = drd;
    req <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rdc

  // ==========================================================
  // Timeout and operating clock watch
  always @(posedge clk) begin
    cyc_cnt++;
    op_q <= op_clk;
    if (op_clk !== op_q) tgl <= tgl + 1;
    if (cyc_cnt == 20000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h18, 32'h0, "port c dir");
    rdc(8'h00, 32'h55, "port a in");
    rdc(8'h04, 32'hA6, "port b in");
    rdc(8'h08, 32'hFF, "port c in");
    rdc(8'h0C, 32'h1F, "port d off");
    check("adc off", adc_en, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1C, 32'(8 + c));
      check("adc select", adc_sel, 32'(5'h1F & (5'h01 << c)));
      rdc(8'h0C, 32'(5'h1F & ~(5'h01 << c)), "port d on");
    end
    wr(8'h10, 32'hFF);
    wr(8'h14, 32'hFF);
    wr(8'h18, 32'hFF);
    check("dirs out", {pa_dir, pb_dir, pc_dir}, 32'h7FFFFF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("dirs reset", {pa_dir, pb_dir, pc_dir}, 32'h0);
    check("adc reset", adc_en, 1'b0);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    t0 = tgl;
    repeat (400) @(posedge clk);
    check("op clk", 32'(tgl - t0), 32'd100);
    wr(8'h20, 32'h1);
    wr(8'h28, 32'h7);
    irq_low <= 1'b1;
    repeat (8) @(posedge clk);
    check("irq out", irq_out, 1'b1);
    check("edge irq", cpu_irq_e, 1'b1);
    wr(8'h24, 32'h1);
    rdc(8'h24, 32'h1, "pin level");
    check("cpu irq", cpu_irq, 1'b1);
    check("edge only", cpu_irq_e, 1'b0);
    irq_low <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'h24, 32'h1);
    rdc(8'h24, 32'h0, "pin clear");
    for (int i = 0; i < 8; i++) begin
      key_low <= 8'h01 << i;
      repeat (8) @(posedge clk);
      rdc(8'h24, 32'h2, "key edge");
      wr(8'h24, 32'h2);
      rdc(8'h24, 32'h0, "key held");
      key_low <= 8'h00;
      repeat (8) @(posedge clk);
    end
    wr(8'h28, 32'h0);
    key_low <= 8'h80;
    repeat (8) @(posedge clk);
    check("masked", irq_out, 1'b0);
    wr(8'h28, 32'h2);
    repeat (2) @(posedge clk);
    check("unmasked", irq_out, 1'b1);
    key_low <= 8'h00;
    wr(8'h24, 32'h2);
    wr(8'h20, 32'h0);
    key_low <= 8'h10;
    repeat (8) @(posedge clk);
    rdc(8'h24, 32'h0, "irq disabled");
    key_low <= 8'h00;
    for (int i = 0; i < 5; i++) begin
      src <= 5'h01 << i;
      @(posedge clk);
      check("pin driven", rst_oe_n, 1'b0);
      check("pin low", rst_o, 1'b0);
      check("reset req", sys_req, 1'b1);
      src <= 5'h00;
      repeat (8) @(posedge clk);
      check("pin stretch", rst_oe_n, 1'b0);
      repeat (6) @(posedge clk);
      check("pin freed", rst_oe_n, 1'b1);
      rdc(8'h2C, 32'(5'h01 << i), "cause");
      wr(8'h2C, 32'h1F);
    end
    ext_rst <= 1'b1;
    repeat (4) @(posedge clk);
    check("ext reset", sys_req, 1'b1);
    ext_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("ext freed", sys_req, 1'b0);
    rdc(8'h30, 32'h0, "unmapped");
    test_done();
  end
endmodule : pirg_glue_tb_top
